// ==== qmc_ctrl.sv ====
// module control, status, interrupt and select logic of the transceiver
`default_nettype none
module qmc_ctrl #(
	parameter int unsigned INIT_CYC = qmc_pkg::INIT_CYC,  // shorten in simulation
	parameter int unsigned WAKE_CYC = qmc_pkg::WAKE_CYC   // shorten in simulation
) (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       ce,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       module_reset_low,
	input  wire logic       module_select_low,
	input  wire logic       low_power_request,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic       sda_drive_req,
	input  wire logic [3:0] rx_los_cond,
	input  wire logic [3:0] tx_fault_cond,
	output logic            sda_out,
	output logic            sda_oe,
	output logic            interrupt_request_low_out,
	output logic            interrupt_request_low_oe,
	output logic            module_present_low,
	output logic            low_power_active,
	output logic            fully_functional,
	output logic            bus_respond
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [qmc_pkg::SY_W-1:0]  sync1_r;        // first stage, read by sync2 only
	logic [qmc_pkg::SY_W-1:0]  sync2_r;        // usable pin levels
	logic                      scl_d_r;        // delayed scl for edges
	logic                      sda_d_r;        // delayed sda for edges
	logic                      stop_seen_r;    // stop seen, awaiting scl fall
	logic                      txn_end;        // scl fall after stop
	logic [7:0]                rst_cnt_r;      // reset pin low filter
	logic                      pin_reset;      // long low recognised
	qmc_pkg::qmc_state_t       state_r;        // control state
	logic [qmc_pkg::TMR_W-1:0] timer_r;        // init / wake timer
	logic                      bus_active_r;   // bus may answer
	logic [7:0]                flags_r;        // latched flags
	logic [7:0]                flag_set;       // flag causes this cycle
	logic [7:0]                clr_pend_r;     // flags read, clear at end
	logic                      rdyf_r;         // ready event flag
	logic                      rdyf_pend_r;    // ready flag read
	logic                      rdy_enter;      // entering ready this cycle
	logic [7:0]                mask_r;         // interrupt masks
	logic                      pdown_r;        // power override
	logic [7:0]                page_r;         // upper page select
	logic [7:0]                rdata_r;        // read data, one cycle
	logic                      int_r;          // interrupt asserted
	logic                      lp_r;           // low power active
	logic                      wr_ok;          // write accepted
	logic                      rd_ok;          // read accepted

	// ---------------------------------------------------------------
	// pin synchronisers and serial stop detection
	// ---------------------------------------------------------------
	// every pin and cause input passes two flops; sda_drive_req and the register strobes do not
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_r <= qmc_pkg::SY_RST_VAL;
			sync2_r <= qmc_pkg::SY_RST_VAL;
		end else if (ce) begin
			sync1_r <= {tx_fault_cond, rx_los_cond, sda_in, scl_in,
			            low_power_request, module_select_low, module_reset_low};
			sync2_r <= sync1_r;
		end
	end

	// stop is sda rising while scl high; end is next scl fall
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_d_r     <= 1'b1;
			sda_d_r     <= 1'b1;
			stop_seen_r <= 1'b0;
		end else if (ce) begin
			scl_d_r <= sync2_r[qmc_pkg::SY_SCL];
			sda_d_r <= sync2_r[qmc_pkg::SY_SDA];
			if (txn_end) begin
				stop_seen_r <= 1'b0;
			end else if (scl_d_r && sync2_r[qmc_pkg::SY_SCL] &&
			             !sda_d_r && sync2_r[qmc_pkg::SY_SDA]) begin
				stop_seen_r <= 1'b1;
			end
		end
	end
	assign txn_end = stop_seen_r && scl_d_r && !sync2_r[qmc_pkg::SY_SCL];

	// ---------------------------------------------------------------
	// reset pin filter
	// ---------------------------------------------------------------
	// a low shorter than the filter is a glitch
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_cnt_r <= 8'h00;
		end else if (ce) begin
			if (sync2_r[qmc_pkg::SY_RST]) begin
				rst_cnt_r <= 8'h00;
			end else if (!pin_reset) begin
				rst_cnt_r <= rst_cnt_r + 8'h01;
			end
		end
	end
	assign pin_reset = (rst_cnt_r == 8'(qmc_pkg::RST_FILT_CYC));

	// ---------------------------------------------------------------
	// readiness state machine
	// ---------------------------------------------------------------
	// power on and pin reset both run the full init time
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= qmc_pkg::ST_INIT;
			timer_r <= '0;
		end else if (ce) begin
			if (pin_reset) begin
				state_r <= qmc_pkg::ST_HOLD;
				timer_r <= '0;
			end else begin
				unique case (state_r)
					qmc_pkg::ST_HOLD: begin
						// wait for the pin to rise
						if (sync2_r[qmc_pkg::SY_RST]) begin
							state_r <= qmc_pkg::ST_INIT;
						end
					end
					qmc_pkg::ST_INIT: begin
						timer_r <= timer_r + 1'b1;
						if (timer_r == qmc_pkg::TMR_W'(INIT_CYC - 1)) begin
							state_r <= qmc_pkg::ST_READY;
							timer_r <= '0;
						end
					end
					qmc_pkg::ST_READY: begin
						// override released: monitors restart
						if (wr_ok && reg_addr == qmc_pkg::ADDR_CTRL && pdown_r &&
						    !reg_wdata[qmc_pkg::CTRL_PDOWN]) begin
							state_r <= qmc_pkg::ST_WAKE;
						end
					end
					qmc_pkg::ST_WAKE: begin
						timer_r <= timer_r + 1'b1;
						if (timer_r == qmc_pkg::TMR_W'(WAKE_CYC - 1)) begin
							state_r <= qmc_pkg::ST_READY;
							timer_r <= '0;
						end
					end
				endcase
			end
		end
	end
	assign rdy_enter = ce && !pin_reset && state_r != qmc_pkg::ST_READY &&
	                   state_r != qmc_pkg::ST_HOLD && timer_r ==
	                   qmc_pkg::TMR_W'((state_r == qmc_pkg::ST_INIT ? INIT_CYC : WAKE_CYC) - 1);

	// ---------------------------------------------------------------
	// bus gating by select
	// ---------------------------------------------------------------
	// silent while deselected or still initialising
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_active_r <= 1'b0;
		end else if (ce) begin
			bus_active_r <= !sync2_r[qmc_pkg::SY_SEL] &&
			                state_r != qmc_pkg::ST_HOLD &&
			                state_r != qmc_pkg::ST_INIT;
		end
	end
	assign wr_ok = reg_wr && bus_active_r;
	assign rd_ok = reg_rd && bus_active_r;

	// ---------------------------------------------------------------
	// flags, clear on read at end of transaction
	// ---------------------------------------------------------------
	assign flag_set = {sync2_r[qmc_pkg::SY_FLT +: 4], sync2_r[qmc_pkg::SY_LOS +: 4]};

	// new causes win over a pending clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_r     <= 8'h00;
			clr_pend_r  <= 8'h00;
			rdyf_r      <= 1'b0;
			rdyf_pend_r <= 1'b0;
		end else if (ce) begin
			if (pin_reset) begin
				flags_r     <= 8'h00;
				clr_pend_r  <= 8'h00;
				rdyf_r      <= 1'b0;
				rdyf_pend_r <= 1'b0;
			end else if (txn_end) begin
				flags_r     <= (flags_r & ~clr_pend_r) | flag_set;
				clr_pend_r  <= 8'h00;
				rdyf_r      <= (rdyf_r && !rdyf_pend_r) || rdy_enter;
				rdyf_pend_r <= 1'b0;
			end else begin
				flags_r <= flags_r | flag_set;
				rdyf_r  <= rdyf_r || rdy_enter;
				if (rd_ok && reg_addr == qmc_pkg::ADDR_FLAGS) begin
					clr_pend_r <= clr_pend_r | flags_r;
				end
				if (rd_ok && reg_addr == qmc_pkg::ADDR_STATUS) begin
					rdyf_pend_r <= rdyf_pend_r || rdyf_r;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// writable registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_r  <= qmc_pkg::MASK_RST;
			pdown_r <= 1'b0;
			page_r  <= qmc_pkg::PAGE_RST;
		end else if (ce) begin
			if (pin_reset) begin
				mask_r  <= qmc_pkg::MASK_RST;
				pdown_r <= 1'b0;
				page_r  <= qmc_pkg::PAGE_RST;
			end else if (wr_ok) begin
				unique case (reg_addr)
					qmc_pkg::ADDR_MASK: mask_r <= reg_wdata;
					qmc_pkg::ADDR_CTRL: pdown_r <= reg_wdata[qmc_pkg::CTRL_PDOWN];
					qmc_pkg::ADDR_PAGE: page_r <= reg_wdata;
					default: ;                               // read-only or unmapped
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// read data, valid in the cycle after the strobe only
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 8'h00;
		end else if (ce) begin
			rdata_r <= 8'h00;
			if (rd_ok) begin
				unique case (reg_addr)
					qmc_pkg::ADDR_STATUS: begin
						rdata_r[qmc_pkg::STAT_DNR]  <= state_r != qmc_pkg::ST_READY;
						rdata_r[qmc_pkg::STAT_RDYF] <= rdyf_r;
					end
					qmc_pkg::ADDR_FLAGS:  rdata_r <= flags_r;
					qmc_pkg::ADDR_MASK:   rdata_r <= mask_r;
					qmc_pkg::ADDR_CTRL:   rdata_r[qmc_pkg::CTRL_PDOWN] <= pdown_r;
					qmc_pkg::ADDR_PSTATE: begin
						rdata_r[qmc_pkg::PST_LP] <= lp_r;
						rdata_r[qmc_pkg::PST_FF] <= state_r == qmc_pkg::ST_READY;
					end
					qmc_pkg::ADDR_PAGE:   rdata_r <= page_r;
					default:              rdata_r <= 8'h00; // unmapped reads zero
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// interrupt and power level
	// ---------------------------------------------------------------
	// any unmasked flag or the ready event holds the line low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			int_r <= 1'b0;
			lp_r  <= 1'b0;
		end else if (ce) begin
			int_r <= (|(flags_r & ~mask_r)) || rdyf_r;
			lp_r  <= sync2_r[qmc_pkg::SY_LP] || pdown_r;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign reg_rdata                 = rdata_r;
	assign interrupt_request_low_out = 1'b0;                     // open drain
	assign interrupt_request_low_oe  = int_r;
	assign sda_out                   = 1'b0;                     // open drain
	assign sda_oe                    = bus_active_r && sda_drive_req;
	assign module_present_low        = 1'b0;                     // always present
	assign low_power_active          = lp_r;
	assign fully_functional          = state_r == qmc_pkg::ST_READY;
	assign bus_respond               = bus_active_r;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	logic [qmc_pkg::TMR_W-1:0] a_init_cnt_r;  // cycles spent initialising
	logic [qmc_pkg::TMR_W-1:0] a_wake_cnt_r;  // cycles spent waking
	logic [7:0]                a_low_cnt_r;   // cycles reset pin low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			a_init_cnt_r <= '0;
			a_wake_cnt_r <= '0;
			a_low_cnt_r  <= 8'h00;
		end else if (ce) begin
			a_init_cnt_r <= (state_r == qmc_pkg::ST_INIT) ? a_init_cnt_r + 1'b1 : '0;
			a_wake_cnt_r <= (state_r == qmc_pkg::ST_WAKE) ? a_wake_cnt_r + 1'b1 : '0;
			a_low_cnt_r  <= sync2_r[qmc_pkg::SY_RST] ? 8'h00 :
			                (a_low_cnt_r == 8'hff ? 8'hff : a_low_cnt_r + 8'h01);
		end
	end

	property p_init_bound;
		a_init_cnt_r <= qmc_pkg::TMR_W'(INIT_CYC);
	endproperty
	a_init_bound: assert property (p_init_bound) else $error("init too long");

	property p_rst_seen;
		a_low_cnt_r > 8'(qmc_pkg::RST_FILT_CYC + 1) |-> state_r == qmc_pkg::ST_HOLD;
	endproperty
	a_rst_seen: assert property (p_rst_seen) else $error("reset pin missed");

	property p_ready_int;
		ce && state_r != qmc_pkg::ST_READY ##1 ce && state_r == qmc_pkg::ST_READY
		|=> ##1 interrupt_request_low_oe;
	endproperty
	a_ready_int: assert property (p_ready_int) else $error("no ready interrupt");

	property p_lp_pin;
		ce && sync2_r[qmc_pkg::SY_LP] |=> low_power_active;
	endproperty
	a_lp_pin: assert property (p_lp_pin) else $error("low power pin ignored");

	property p_flag_set;
		ce && !pin_reset && |flag_set |=> (flags_r & $past(flag_set)) == $past(flag_set);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not latched");

	property p_unmasked_int;
		ce && |(flags_r & ~mask_r) |=> interrupt_request_low_oe;
	endproperty
	a_unmasked_int: assert property (p_unmasked_int) else $error("int not held");

	property p_masked_quiet;
		ce && (flags_r & ~mask_r) == 8'h00 && !rdyf_r |=> !interrupt_request_low_oe;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("int not released");

	property p_clear_read;
		ce && !pin_reset && txn_end && flag_set == 8'h00
		|=> (flags_r & $past(clr_pend_r)) == 8'h00;
	endproperty
	a_clear_read: assert property (p_clear_read) else $error("flag not cleared");

	property p_sel_off;
		ce && sync2_r[qmc_pkg::SY_SEL] |=> !sda_oe && !bus_respond;
	endproperty
	a_sel_off: assert property (p_sel_off) else $error("bus not silenced");

	property p_sel_on;
		ce && !sync2_r[qmc_pkg::SY_SEL] && state_r == qmc_pkg::ST_READY |=> bus_respond;
	endproperty
	a_sel_on: assert property (p_sel_on) else $error("bus not enabled");

	property p_pdown;
		ce && wr_ok && reg_addr == qmc_pkg::ADDR_CTRL && reg_wdata[qmc_pkg::CTRL_PDOWN]
		##1 ce |=> low_power_active;
	endproperty
	a_pdown: assert property (p_pdown) else $error("override ignored");

	property p_wake_bound;
		a_wake_cnt_r <= qmc_pkg::TMR_W'(WAKE_CYC);
	endproperty
	a_wake_bound: assert property (p_wake_bound) else $error("wake too long");

	c_ready:   cover property (state_r == qmc_pkg::ST_INIT ##1 state_r == qmc_pkg::ST_READY);
	c_flagclr: cover property (txn_end && clr_pend_r != 8'h00);
	c_wake:    cover property (state_r == qmc_pkg::ST_WAKE ##1 state_r == qmc_pkg::ST_READY);
	c_hold:    cover property (state_r == qmc_pkg::ST_HOLD);
endmodule
`default_nettype wire

// ==== qmc_pkg.sv ====
// constants, register map and types of the module control and status block
`default_nettype none
package qmc_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;       // 100 mhz core clock
	localparam int unsigned T_INIT_MS     = 2000;     // init / reset to ready
	localparam int unsigned T_RST_REC_NS  = 2000;     // reset pin recognition
	localparam int unsigned T_PDOWN_OFF_MS = 300;     // override cleared to ready
	localparam int unsigned NS_PER_MS     = 1000000;
	// cycle counts, longest times round down
	localparam int unsigned INIT_CYC = T_INIT_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int unsigned WAKE_CYC = T_PDOWN_OFF_MS * (NS_PER_MS / CLK_PERIOD_NS);
	// half the window is filtering, the rest is sync and slack
	localparam int unsigned RST_FILT_CYC = T_RST_REC_NS / CLK_PERIOD_NS / 2;
	localparam int unsigned TMR_W = 28;               // holds INIT_CYC
	// ---------------------------------------------------------------
	// register map, lower page
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h02;       // ready bits
	localparam logic [7:0] ADDR_FLAGS  = 8'h03;       // latched flags
	localparam logic [7:0] ADDR_MASK   = 8'h04;       // interrupt masks
	localparam logic [7:0] ADDR_CTRL   = 8'h05;       // power override
	localparam logic [7:0] ADDR_PSTATE = 8'h06;       // power state
	localparam logic [7:0] ADDR_PAGE   = 8'h7f;       // upper page select
	localparam logic [7:0] MASK_RST    = 8'h00;
	localparam logic [7:0] PAGE_RST    = 8'h00;
	localparam int unsigned STAT_DNR   = 0;           // data not ready
	localparam int unsigned STAT_RDYF  = 1;           // ready event flag
	localparam int unsigned CTRL_PDOWN = 0;           // power override bit
	localparam int unsigned PST_LP     = 0;           // low power active
	localparam int unsigned PST_FF     = 1;           // fully functional
	// ---------------------------------------------------------------
	// pin synchroniser layout
	// ---------------------------------------------------------------
	localparam int unsigned SY_RST  = 0;
	localparam int unsigned SY_SEL  = 1;
	localparam int unsigned SY_LP   = 2;
	localparam int unsigned SY_SCL  = 3;
	localparam int unsigned SY_SDA  = 4;
	localparam int unsigned SY_LOS  = 5;              // 4 bits
	localparam int unsigned SY_FLT  = 9;              // 4 bits
	localparam int unsigned SY_W    = 13;
	localparam logic [12:0] SY_RST_VAL = 13'h001b;    // idle pin levels
	// ---------------------------------------------------------------
	// control state
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_INIT,
		ST_READY,
		ST_WAKE
	} qmc_state_t;
endpackage
`default_nettype wire

// ==== qmc_host_model.sv ====
// host controller model driving the sideband pins and serial bus lines
`default_nettype none
module qmc_host_model #(
	parameter int unsigned RST_MIN_CYC = 1000  // shortest reset pulse, 10 us
) (
	input  wire logic clk,
	output logic      module_reset_low,
	output logic      module_select_low,
	output logic      low_power_request,
	output logic      scl,
	output logic      sda_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// pin levels and serial frames
	// ---------------------------------------------------------------
	// idle: out of reset, selected, full power, bus released
	initial begin
		module_reset_low  = 1'b1;
		module_select_low = 1'b0;
		low_power_request = 1'b0;
		scl               = 1'b1;
		sda_drv           = 1'b1;
	end
	// a quarter of the 320 ns serial clock period
	task automatic half_bit();
		repeat (8) @(posedge clk);
	endtask
	// reset pulse held for exactly its minimum width
	task automatic pulse_reset();
		@(posedge clk);
		module_reset_low <= 1'b0;
		repeat (RST_MIN_CYC) @(posedge clk);
		module_reset_low <= 1'b1;
	endtask
	// select pin, active low on the wire
	task automatic set_select(input logic active);
		@(posedge clk);
		module_select_low <= ~active;
	endtask
	// low-power request pin
	task automatic set_low_power(input logic req);
		@(posedge clk);
		low_power_request <= req;
	endtask
	// stop condition then the clock fall that ends the transaction
	task automatic end_txn();
		@(posedge clk);
		scl <= 1'b0;
		half_bit();
		sda_drv <= 1'b0;
		half_bit();
		scl <= 1'b1;
		half_bit();
		sda_drv <= 1'b1;
		half_bit();
		scl <= 1'b0;
		half_bit();
		scl <= 1'b1; // clock stands high between frames
	endtask
endmodule
`default_nettype wire

// ==== qmc_ctrl_tb.sv ====
// self-checking bench of the module control and status block
`default_nettype none
module qmc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// setup
	// ---------------------------------------------------------------
	localparam int unsigned INIT_N = 50;  // shortened init count
	localparam int unsigned WAKE_N = 20;  // shortened wake count
	localparam int unsigned PIN_N  = 20;  // bound for pin to output paths
	localparam int unsigned S_IRQ = 0, S_FF = 1, S_BUS = 2, S_LP = 3;
	logic       clk, arst_n, ce, reg_wr, reg_rd, sda_drive_req;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [3:0] rx_los_cond, tx_fault_cond;
	wire logic  rst_l, sel_l, lp_req, scl, sda_drv;
	logic       sda_oe, irq_oe, low_power_active, fully_functional, bus_respond;
	logic       mod_prs_l, irq_out, sda_lvl;  // constant open-drain levels
	int         mismatches, checks_done;
	wire logic  sda_in = sda_drv & ~sda_oe;  // pulled-up data line
	always #5 clk = ~clk;
	qmc_host_model host (.clk(clk), .module_reset_low(rst_l), .module_select_low(sel_l),
		.low_power_request(lp_req), .scl(scl), .sda_drv(sda_drv));
	qmc_ctrl #(.INIT_CYC(INIT_N), .WAKE_CYC(WAKE_N)) dut (.clk(clk), .arst_n(arst_n),
		.ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .module_reset_low(rst_l),
		.module_select_low(sel_l), .low_power_request(lp_req), .scl_in(scl),
		.sda_in(sda_in), .sda_drive_req(sda_drive_req), .rx_los_cond(rx_los_cond),
		.tx_fault_cond(tx_fault_cond), .sda_out(sda_lvl), .sda_oe(sda_oe),
		.interrupt_request_low_out(irq_out), .interrupt_request_low_oe(irq_oe),
		.module_present_low(mod_prs_l), .low_power_active(low_power_active),
		.fully_functional(fully_functional), .bus_respond(bus_respond));
	// ---------------------------------------------------------------
	// checks and bus tasks
	// ---------------------------------------------------------------
	task automatic stop_test();
		if (mismatches == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic fail(input string msg);
		mismatches++;
		$display("CHECK FAILED t=%0t %s", $time, msg);
	endtask
	task automatic chk1(input logic got, input logic exp, input string msg);
		checks_done++;
		if (got !== exp) fail(msg);
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) fail("read data");
	endtask
	// status output chosen by index
	function automatic logic pick(input int unsigned which);
		case (which)
			S_IRQ:   pick = irq_oe;
			S_FF:    pick = fully_functional;
			S_BUS:   pick = bus_respond;
			default: pick = low_power_active;
		endcase
	endfunction
	// bounded wait for an output level, run ends if it never comes
	task automatic wait_sig(input int unsigned which, input logic val, input int unsigned bound);
		int unsigned n;
		n = 0;
		#1;
		while (pick(which) !== val && n < bound) begin
			@(posedge clk);
			#1;
			n++;
		end
		checks_done++;
		if (pick(which) !== val) begin
			fail("output not settled in time");
			stop_test();
		end
	endtask
	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		reg_addr  <= addr;
		reg_wdata <= data;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= addr;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk8(reg_rdata, exp);
	endtask
	// set both fault inputs at once
	task automatic set_cause(input logic [7:0] v);
		@(posedge clk);
		{tx_fault_cond, rx_los_cond} <= v;
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		clk = 0;
		arst_n = 0;
		ce = 1;
		reg_addr = 0;
		reg_wdata = 0;
		reg_wr = 0;
		reg_rd = 0;
		sda_drive_req = 0;
		rx_los_cond = 0;
		tx_fault_cond = 0;
		mismatches = 0;
		checks_done = 0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		chk1(irq_oe | bus_respond | fully_functional, 1'b0, "reset outputs");
		chk1(mod_prs_l | irq_out | sda_lvl, 1'b0, "open drain levels");
		wait_sig(S_FF, 1'b1, INIT_N + PIN_N);
		wait_sig(S_BUS, 1'b1, PIN_N);
		wait_sig(S_IRQ, 1'b1, PIN_N);
		reg_read(qmc_pkg::ADDR_STATUS, 8'h02);
		host.end_txn();
		wait_sig(S_IRQ, 1'b0, PIN_N);
		reg_read(qmc_pkg::ADDR_STATUS, 8'h00);
		reg_read(8'h10, 8'h00);
		reg_write(qmc_pkg::ADDR_FLAGS, 8'hff);
		reg_read(qmc_pkg::ADDR_FLAGS, 8'h00);
		// every lane loss and fault, one at a time
		for (int i = 0; i < 8; i++) begin
			set_cause(8'h01 << i);
			wait_sig(S_IRQ, 1'b1, PIN_N);
			reg_read(qmc_pkg::ADDR_FLAGS, 8'h01 << i);
			set_cause(8'h00);
			host.end_txn();
			wait_sig(S_IRQ, 1'b0, PIN_N);
		end
		// a persisting cause keeps the interrupt up
		set_cause(8'h81);
		wait_sig(S_IRQ, 1'b1, PIN_N);
		reg_read(qmc_pkg::ADDR_FLAGS, 8'h81);
		set_cause(8'h80);
		host.end_txn();
		repeat (PIN_N) @(posedge clk);
		#1;
		chk1(irq_oe, 1'b1, "interrupt held");
		reg_read(qmc_pkg::ADDR_FLAGS, 8'h80);
		set_cause(8'h00);
		host.end_txn();
		wait_sig(S_IRQ, 1'b0, PIN_N);
		// masking and unmasking
		reg_write(qmc_pkg::ADDR_MASK, 8'h01);
		reg_read(qmc_pkg::ADDR_MASK, 8'h01);
		set_cause(8'h01);
		repeat (PIN_N) @(posedge clk);
		#1;
		chk1(irq_oe, 1'b0, "masked flag");
		reg_write(qmc_pkg::ADDR_MASK, 8'h00);
		wait_sig(S_IRQ, 1'b1, PIN_N);
		set_cause(8'h00);
		reg_read(qmc_pkg::ADDR_FLAGS, 8'h01);
		host.end_txn();
		wait_sig(S_IRQ, 1'b0, PIN_N);
		// low power by pin and by override
		host.set_low_power(1'b1);
		wait_sig(S_LP, 1'b1, PIN_N);
		host.set_low_power(1'b0);
		wait_sig(S_LP, 1'b0, PIN_N);
		reg_write(qmc_pkg::ADDR_CTRL, 8'h01);
		wait_sig(S_LP, 1'b1, PIN_N);
		reg_read(qmc_pkg::ADDR_CTRL, 8'h01);
		reg_read(qmc_pkg::ADDR_PSTATE, 8'h03);
		reg_write(qmc_pkg::ADDR_PAGE, 8'h03);
		reg_read(qmc_pkg::ADDR_PAGE, 8'h03);
		reg_write(qmc_pkg::ADDR_CTRL, 8'h00);
		wait_sig(S_FF, 1'b0, PIN_N);
		reg_read(qmc_pkg::ADDR_STATUS, 8'h01);
		wait_sig(S_FF, 1'b1, WAKE_N + PIN_N);
		wait_sig(S_IRQ, 1'b1, PIN_N);
		reg_read(qmc_pkg::ADDR_STATUS, 8'h02);
		wait_sig(S_LP, 1'b0, PIN_N);
		// select gating of the bus and the data line
		reg_write(qmc_pkg::ADDR_MASK, 8'h3c);
		@(posedge clk);
		sda_drive_req <= 1'b1;
		@(posedge clk);
		#1;
		chk1(sda_oe, 1'b1, "data line drive");
		host.set_select(1'b0);
		wait_sig(S_BUS, 1'b0, PIN_N);
		chk1(sda_oe, 1'b0, "line driven unselected");
		reg_write(qmc_pkg::ADDR_MASK, 8'hff);
		reg_read(qmc_pkg::ADDR_MASK, 8'h00);
		host.set_select(1'b1);
		wait_sig(S_BUS, 1'b1, PIN_N);
		reg_read(qmc_pkg::ADDR_MASK, 8'h3c);
		// clock enable low freezes the block, strobes are ignored
		@(posedge clk);
		ce <= 1'b0;
		reg_write(qmc_pkg::ADDR_MASK, 8'h55);
		@(posedge clk);
		ce <= 1'b1;
		reg_read(qmc_pkg::ADDR_MASK, 8'h3c);
		// reset pin recognised, then a full init again
		fork
			host.pulse_reset();
			wait_sig(S_FF, 1'b0, 200);
		join
		chk1(sda_oe, 1'b0, "line driven in init");
		wait_sig(S_FF, 1'b1, INIT_N + PIN_N);
		wait_sig(S_BUS, 1'b1, PIN_N);
		reg_read(qmc_pkg::ADDR_MASK, 8'h00);
		reg_read(qmc_pkg::ADDR_PAGE, 8'h00);
		wait_sig(S_IRQ, 1'b1, PIN_N);
		stop_test();
	end
endmodule
`default_nettype wire
